// ==== rtl/tccd_params.svh ====
// Offsets, field positions and reset values of the timer block.
`ifndef TCCD_PARAMS_SVH
`define TCCD_PARAMS_SVH

`define TCCD_MASK_IDX        8'hFF
`define TCCD_MASK_ADDR       12'h3FC
`define TCCD_CTRL_ADDR       12'h000
`define TCCD_COUNT_ADDR      12'h004
`define TCCD_CAPT_ADDR       12'h008
`define TCCD_CMP_ADDR        12'h00C
`define TCCD_STAT_ADDR       12'h010
`define TCCD_DCNT_ADDR       12'h014
`define TCCD_DADDR_ADDR      12'h018
`define TCCD_CP_DMA_BIT      6
`define TCCD_CM_DMA_BIT      3
`define TCCD_MASK_RESET      8'h00
`define TCCD_CTRL_RESET      8'h00
`define TCCD_CTRL_RUN_BIT    0
`define TCCD_CTRL_EDGE_LSB   1
`define TCCD_CTRL_CAPEN_BIT  3
`define TCCD_CTRL_CMPEN_BIT  4
`define TCCD_CTRL_PSC_LSB    5
`define TCCD_CAPT_FLAG_BIT   0
`define TCCD_CMP_FLAG_BIT    1

`endif

// ==== rtl/tccd_pkg.sv ====
// Types shared by the timer capture/compare block.
package tccd_pkg;

    typedef logic [15:0] tccd_word_t;
    typedef logic [7:0]  tccd_byte_t;

    typedef enum logic [1:0] {
        TCCD_EDGE_RISE,
        TCCD_EDGE_FALL,
        TCCD_EDGE_BOTH,
        TCCD_EDGE_NONE
    } tccd_edge_e;

    typedef enum {
        TCCD_DMA_IDLE,
        TCCD_DMA_REQ
    } tccd_dma_e;

endpackage : tccd_pkg

// ==== rtl/tccd_sync3.sv ====
// Three-stage synchroniser with agreement on the last two stages.
`timescale 1ns/10ps
module tccd_sync3 (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous input and its settled level.
    input  wire logic async_in,
    output logic      sync_out
);

    logic [2:0] stage_ff;
    logic       nxt_sync_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_ff <= 3'h0;
        end else begin
            stage_ff <= {stage_ff[1:0], async_in};
        end
    end

    // The level changes only once stages two and three agree.
    assign nxt_sync_out = (stage_ff[1] == stage_ff[2]) ? stage_ff[2]
                                                       : sync_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= 1'b0;
        end else begin
            sync_out <= nxt_sync_out;
        end
    end

endmodule : tccd_sync3

// ==== rtl/tccd_buf2.sv ====
// Two-entry valid/ready buffer for the DMA data path.
`timescale 1ns/10ps
module tccd_buf2 #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_ff [2];
    logic             wr_ptr_ff;
    logic             rd_ptr_ff;
    logic [1:0]       count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule : tccd_buf2

// ==== rtl/tccd_timer.sv ====
// Capture/compare timer channel with interrupt or DMA event routing.
//
// Overview of operation
// - An input event copies the 16-bit running count into the capture reg.
// - A counter match with the compare value toggles the compare pin.
// - Each event raises an interrupt or DMA request by mode; a capture with both entries held, or a compare match with a request pending, raises neither.
// - Mask bit 6 set sends capture events to DMA instead of interrupt.
// - Mask bit 3 set sends compare events to DMA instead of interrupt.
// - In DMA mode values move to or from memory with no CPU involvement.
// - Count and address registers hold remaining transfers and location.
// - Block done for a channel clears that channel's DMA mask bit.
// - With its mask bit clear a channel issues no DMA requests.
`timescale 1ns/10ps
`include "tccd_params.svh"
module tccd_timer (
    // APB slave.
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Timer pins.
    input  wire logic                 capture_in,
    output logic                      compare_out,
    // Interrupt requests.
    output logic                      capture_irq,
    output logic                      compare_irq,
    // DMA requests, acknowledges and block done.
    output logic                      cap_dma_req,
    input  wire logic                 cap_dma_ack,
    output logic                      cmp_dma_req,
    input  wire logic                 cmp_dma_ack,
    input  wire logic                 cap_block_done_event,
    input  wire logic                 cmp_block_done_event,
    // DMA data: captured values out, compare values in.
    output tccd_pkg::tccd_word_t      cap_dma_data,
    input  wire tccd_pkg::tccd_word_t cmp_dma_data,
    // Capture data stream through the two-entry buffer.
    output logic                      cap_out_valid,
    input  wire logic                 cap_out_ready,
    // Transfer state mirrored by the controller.
    input  wire tccd_pkg::tccd_word_t dma_count,
    input  wire tccd_pkg::tccd_word_t dma_addr
);

    import tccd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus decode.

    tccd_byte_t  event_dma_select_mask_ff;
    tccd_byte_t  ctrl_ff;
    tccd_word_t  count_ff;
    tccd_word_t  capture_value_reg_ff;
    tccd_word_t  compare_value_reg_ff;
    tccd_word_t  dma_count_ff;
    tccd_word_t  dma_addr_ff;
    logic [1:0]  flag_ff;
    logic [2:0]  psc_ff;
    logic        pin_sync;
    logic        pin_prev_ff;
    logic        wr_en;
    logic        rd_en;
    logic        capture_dma_enable;
    logic        compare_dma_enable;
    logic        tick;
    logic        cap_event;
    logic        cmp_event;
    logic        cap_push_ready;
    logic        mapped;
    tccd_edge_e  edge_sel;
    tccd_dma_e   cap_state_ff;
    tccd_dma_e   cmp_state_ff;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr == `TCCD_MASK_ADDR) || (paddr == `TCCD_CTRL_ADDR)
                  || (paddr == `TCCD_COUNT_ADDR) || (paddr == `TCCD_CAPT_ADDR)
                  || (paddr == `TCCD_CMP_ADDR) || (paddr == `TCCD_STAT_ADDR)
                  || (paddr == `TCCD_DCNT_ADDR)
                  || (paddr == `TCCD_DADDR_ADDR);
    assign pslverr = psel && penable && !mapped;

    assign capture_dma_enable = event_dma_select_mask_ff[`TCCD_CP_DMA_BIT];
    assign compare_dma_enable = event_dma_select_mask_ff[`TCCD_CM_DMA_BIT];
    assign edge_sel = tccd_edge_e'(ctrl_ff[`TCCD_CTRL_EDGE_LSB +: 2]);

    ////////////////////////////////////////////////////////////////////////
    // Mask register: software writes, block done clears.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_dma_select_mask_ff <= `TCCD_MASK_RESET;
        end else begin
            if (wr_en && paddr == `TCCD_MASK_ADDR) begin
                event_dma_select_mask_ff <= pwdata[7:0];
            end
            if (cap_block_done_event) begin
                event_dma_select_mask_ff[`TCCD_CP_DMA_BIT] <= 1'b0;
            end
            if (cmp_block_done_event) begin
                event_dma_select_mask_ff[`TCCD_CM_DMA_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `TCCD_CTRL_RESET;
        end else if (wr_en && paddr == `TCCD_CTRL_ADDR) begin
            ctrl_ff <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaled 16-bit counter.

    assign tick = ctrl_ff[`TCCD_CTRL_RUN_BIT]
               && (psc_ff == ctrl_ff[`TCCD_CTRL_PSC_LSB +: 3]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_ff <= 3'h0;
        end else if (tick || !ctrl_ff[`TCCD_CTRL_RUN_BIT]) begin
            psc_ff <= 3'h0;
        end else begin
            psc_ff <= psc_ff + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 16'h0000;
        end else if (wr_en && paddr == `TCCD_COUNT_ADDR) begin
            count_ff <= pwdata[15:0];
        end else if (tick) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input capture.

    tccd_sync3 u_cap_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (capture_in),
        .sync_out (pin_sync)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_ff <= 1'b0;
        end else begin
            pin_prev_ff <= pin_sync;
        end
    end

    always_comb begin
        case (edge_sel)
            TCCD_EDGE_RISE: cap_event = pin_sync && !pin_prev_ff;
            TCCD_EDGE_FALL: cap_event = !pin_sync && pin_prev_ff;
            TCCD_EDGE_BOTH: cap_event = pin_sync != pin_prev_ff;
            default:        cap_event = 1'b0;
        endcase
        cap_event = cap_event && ctrl_ff[`TCCD_CTRL_CAPEN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_reg_ff <= 16'h0000;
        end else if (cap_event) begin
            capture_value_reg_ff <= count_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output compare.

    assign cmp_event = ctrl_ff[`TCCD_CTRL_CMPEN_BIT] && tick
                    && (count_ff == compare_value_reg_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out <= 1'b0;
        end else if (cmp_event) begin
            compare_out <= ~compare_out;
        end
    end

    // The next compare value arrives on the acknowledge of a DMA fetch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_reg_ff <= 16'hFFFF;
        end else if (cmp_state_ff == TCCD_DMA_REQ && cmp_dma_ack) begin
            compare_value_reg_ff <= cmp_dma_data;
        end else if (wr_en && paddr == `TCCD_CMP_ADDR) begin
            compare_value_reg_ff <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags, set wins over a software clear.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 2'h0;
        end else begin
            if (wr_en && paddr == `TCCD_STAT_ADDR) begin
                flag_ff <= flag_ff & ~pwdata[1:0];
            end
            if (cap_event && !capture_dma_enable) begin
                flag_ff[`TCCD_CAPT_FLAG_BIT] <= 1'b1;
            end
            if (cmp_event && !compare_dma_enable) begin
                flag_ff[`TCCD_CMP_FLAG_BIT] <= 1'b1;
            end
        end
    end

    assign capture_irq = flag_ff[`TCCD_CAPT_FLAG_BIT];
    assign compare_irq = flag_ff[`TCCD_CMP_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////
    // DMA request handshakes.

    // Captured values queue two deep; a capture arriving while both entries are held is dropped.
    tccd_buf2 #(.WIDTH(16)) u_cap_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (cap_event && capture_dma_enable),
        .in_ready  (cap_push_ready),
        .in_data   (count_ff),
        .out_valid (cap_out_valid),
        .out_ready (cap_out_ready),
        .out_data  (cap_dma_data)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_state_ff <= TCCD_DMA_IDLE;
        end else begin
            case (cap_state_ff)
                // A word queued behind an earlier request is asked for too.
                TCCD_DMA_IDLE: begin
                    if (capture_dma_enable && (cap_out_valid
                        || (cap_event && cap_push_ready))) begin
                        cap_state_ff <= TCCD_DMA_REQ;
                    end
                end
                TCCD_DMA_REQ: begin
                    if (cap_dma_ack) begin
                        cap_state_ff <= TCCD_DMA_IDLE;
                    end
                end
                default: cap_state_ff <= TCCD_DMA_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_state_ff <= TCCD_DMA_IDLE;
        end else begin
            case (cmp_state_ff)
                TCCD_DMA_IDLE: begin
                    if (cmp_event && compare_dma_enable) begin
                        cmp_state_ff <= TCCD_DMA_REQ;
                    end
                end
                TCCD_DMA_REQ: begin
                    if (cmp_dma_ack) begin
                        cmp_state_ff <= TCCD_DMA_IDLE;
                    end
                end
                default: cmp_state_ff <= TCCD_DMA_IDLE;
            endcase
        end
    end

    assign cap_dma_req = (cap_state_ff == TCCD_DMA_REQ);
    assign cmp_dma_req = (cmp_state_ff == TCCD_DMA_REQ);

    ////////////////////////////////////////////////////////////////////////
    // Transfer count and address mirror, kept by the controller.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_count_ff <= 16'h0000;
            dma_addr_ff  <= 16'h0000;
        end else begin
            dma_count_ff <= dma_count;
            dma_addr_ff  <= dma_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en && !penable) begin
            case (paddr)
                `TCCD_MASK_ADDR:  prdata <= {24'h0, event_dma_select_mask_ff};
                `TCCD_CTRL_ADDR:  prdata <= {24'h0, ctrl_ff};
                `TCCD_COUNT_ADDR: prdata <= {16'h0, count_ff};
                `TCCD_CAPT_ADDR:  prdata <= {16'h0, capture_value_reg_ff};
                `TCCD_CMP_ADDR:   prdata <= {16'h0, compare_value_reg_ff};
                `TCCD_STAT_ADDR:  prdata <= {30'h0, flag_ff};
                `TCCD_DCNT_ADDR:  prdata <= {16'h0, dma_count_ff};
                `TCCD_DADDR_ADDR: prdata <= {16'h0, dma_addr_ff};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end

endmodule : tccd_timer

// ==== dv/tccd_timer_properties.sv ====
// Concurrent checks on the timer's DMA and interrupt event routing.
`timescale 1ns/10ps
`include "tccd_params.svh"
module tccd_timer_props (
    // Clock, reset and APB request.
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Event outputs and DMA handshake.
    input wire logic        compare_out,
    input wire logic        compare_irq,
    input wire logic        cap_dma_req,
    input wire logic        cap_dma_ack,
    input wire logic        cmp_dma_req,
    input wire logic        cmp_dma_ack,
    input wire logic        cap_block_done_event,
    input wire logic        cmp_block_done_event
);
    logic [1:0] m_ff;
    logic       mask_wr;
    assign mask_wr = psel && penable && pwrite && paddr == `TCCD_MASK_ADDR;
    // Mirror of the capture and compare DMA mask bits; block done wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_ff <= 2'h0;
        end else begin
            if (mask_wr)
                m_ff <= {pwdata[`TCCD_CP_DMA_BIT], pwdata[`TCCD_CM_DMA_BIT]};
            if (cap_block_done_event)
                m_ff[1] <= 1'b0;
            if (cmp_block_done_event)
                m_ff[0] <= 1'b0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_cap_req_hold: assert property (
        cap_dma_req && !cap_dma_ack |=> cap_dma_req) else $error("cap hold");
    a_cap_req_drop: assert property (
        cap_dma_req && cap_dma_ack |=> !cap_dma_req) else $error("cap drop");
    a_cmp_req_hold: assert property (
        cmp_dma_req && !cmp_dma_ack |=> cmp_dma_req) else $error("cmp hold");
    a_cmp_req_drop: assert property (
        cmp_dma_req && cmp_dma_ack |=> !cmp_dma_req) else $error("cmp drop");
    a_cap_dma_off: assert property (
        !m_ff[1] && !$past(m_ff[1]) |-> !$rose(cap_dma_req))
        else $error("capture request with mask clear");
    a_cmp_dma_off: assert property (
        !m_ff[0] && !$past(m_ff[0]) |-> !$rose(cmp_dma_req))
        else $error("compare request with mask clear");
    a_cmp_irq_route: assert property (
        m_ff[0] && $past(m_ff[0]) |-> !$rose(compare_irq))
        else $error("compare interrupt in dma mode");
    a_cmp_dma_event: assert property (
        $changed(compare_out) && $past(m_ff[0]) && !$past(cmp_dma_req)
        |-> ##[0:1] cmp_dma_req) else $error("compare match without request");
    a_cmp_irq_event: assert property (
        $changed(compare_out) && !m_ff[0] && !$past(m_ff[0])
        |-> ##[0:1] compare_irq) else $error("compare match without irq");
    cover property ($rose(cap_dma_req));
    cover property (cmp_block_done_event);
    cover property ($changed(compare_out) && !m_ff[0]);
endmodule : tccd_timer_props

// ==== dv/tccd_dma_model.sv ====
// Behavioural DMA controller serving the timer's two request channels.
`timescale 1ns/10ps
module tccd_dma_model (
    // Clock, reset, pacing and block setup.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  lat,
    input  wire logic        load,
    input  wire logic [15:0] load_cnt,
    input  wire logic [15:0] load_addr,
    // Requests, answers and block done.
    input  wire logic        cap_dma_req,
    output logic             cap_dma_ack,
    input  wire logic        cmp_dma_req,
    output logic             cmp_dma_ack,
    output logic             cap_block_done_event,
    output logic             cmp_block_done_event,
    // Data paths and transfer state.
    input  wire logic        cap_out_valid,
    output logic             cap_out_ready,
    input  wire logic [15:0] cap_dma_data,
    output logic      [15:0] cmp_dma_data,
    output logic      [15:0] dma_count,
    output logic      [15:0] dma_addr
);
    logic [15:0] mem [16];
    logic [3:0]  wait_ff;
    logic        cap_go;
    logic        cmp_go;
    assign cap_go = cap_dma_req && !cap_dma_ack && cap_out_valid;
    assign cmp_go = cmp_dma_req && !cmp_dma_ack;
    // Serves one request after lat idle cycles; the data line toggles idle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cap_dma_ack, cmp_dma_ack, cap_out_ready} <= 3'h0;
            {cap_block_done_event, cmp_block_done_event} <= 2'h0;
            {dma_count, dma_addr} <= 32'h0;
            cmp_dma_data <= 16'hFFFF;
            wait_ff <= 4'h0;
        end else begin
            {cap_dma_ack, cmp_dma_ack, cap_out_ready} <= 3'h0;
            {cap_block_done_event, cmp_block_done_event} <= 2'h0;
            cmp_dma_data <= ~cmp_dma_data;
            if (load) begin
                dma_count <= load_cnt;
                dma_addr <= load_addr;
            end else if ((cap_go || cmp_go) && wait_ff < lat) begin
                wait_ff <= wait_ff + 4'h1;
            end else if (cap_go || cmp_go) begin
                wait_ff <= 4'h0;
                dma_count <= dma_count - 16'h1;
                dma_addr <= dma_addr + 16'h1;
                if (cap_go) begin
                    cap_dma_ack <= 1'b1;
                    cap_out_ready <= 1'b1;
                    mem[dma_addr[3:0]] <= cap_dma_data;
                    cap_block_done_event <= dma_count == 16'h1;
                end else begin
                    cmp_dma_ack <= 1'b1;
                    cmp_dma_data <= mem[dma_addr[3:0]];
                    cmp_block_done_event <= dma_count == 16'h1;
                end
            end
        end
    end
endmodule : tccd_dma_model

// ==== dv/tb.sv ====
// Self-checking bench for the timer capture/compare block.
`timescale 1ns/10ps
`include "tccd_params.svh"
module tb;
    import tccd_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d, q; logic e;} tccd_row_s;
    logic        pclk = 1'b0, presetn = 1'b0, capture_in = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, load = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  lat = 4'h0;
    tccd_word_t  load_cnt = 16'h0, load_addr = 16'h0, want;
    logic        pready, pslverr, compare_out, capture_irq, compare_irq, er;
    logic        cap_dma_req, cap_dma_ack, cmp_dma_req, cmp_dma_ack;
    logic        cap_block_done_event, cmp_block_done_event;
    logic        cap_out_valid, cap_out_ready;
    tccd_word_t  cap_dma_data, cmp_dma_data, dma_count, dma_addr;
    int          errors = 0, checks = 0, tog = 0;
    tccd_row_s   rows [5] = '{'{`TCCD_MASK_ADDR, 32'hFF, 32'hFF, 1'b0},
        '{`TCCD_MASK_ADDR, 32'h0, 32'h0, 1'b0},
        '{`TCCD_CMP_ADDR, 32'hABCD, 32'hABCD, 1'b0},
        '{`TCCD_DCNT_ADDR, 32'h5A5A, 32'h0, 1'b0},
        '{12'h020, 32'h5A5A, 32'h0, 1'b1}};

    tccd_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .capture_in, .compare_out,
        .capture_irq, .compare_irq, .cap_dma_req, .cap_dma_ack, .cmp_dma_req,
        .cmp_dma_ack, .cap_block_done_event, .cmp_block_done_event,
        .cap_dma_data, .cmp_dma_data, .cap_out_valid, .cap_out_ready,
        .dma_count, .dma_addr);
    tccd_dma_model model (.pclk, .presetn, .lat, .load, .load_cnt,
        .load_addr, .cap_dma_req, .cap_dma_ack, .cmp_dma_req, .cmp_dma_ack,
        .cap_block_done_event, .cmp_block_done_event, .cap_out_valid,
        .cap_out_ready, .cap_dma_data, .cmp_dma_data, .dma_count, .dma_addr);

    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(compare_out) tog++;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic stop_run();
        errors++;
        final_report();
    endtask : stop_run
    // One APB transfer; it starts after a clock edge and ends on one.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16)
            stop_run();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic pick(input int k);
        case (k)
            0: return capture_irq === 1'b1;
            1: return dma_count === want;
            default: return tog == want;
        endcase
    endfunction : pick
    task automatic wait_on(input int k);
        int m;
        m = 0;
        while (!pick(k) && m < 3000) begin
            @(posedge pclk);
            m++;
        end
        if (m >= 3000)
            stop_run();
    endtask : wait_on
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TCCD_MASK_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `TCCD_CMP_ADDR, 32'h0);
        chk(rd, 32'hFFFF);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk(er, rows[i].e);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].q);
        end
        model.mem[4] = 16'h0080;
        model.mem[5] = 16'h00C0;
        model.mem[6] = 16'h0100;
        load_cnt <= 16'h3;
        load_addr <= 16'h4;
        load <= 1'b1;
        apb(1'b1, `TCCD_CMP_ADDR, 32'h40);
        load <= 1'b0;
        apb(1'b1, `TCCD_COUNT_ADDR, 32'h0);
        apb(1'b1, `TCCD_MASK_ADDR, 32'h08);
        tog = 0;
        apb(1'b1, `TCCD_CTRL_ADDR, 32'h11);
        want = 16'h4;
        wait_on(2);
        chk(tog, 32'h4);
        apb(1'b0, `TCCD_MASK_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `TCCD_CMP_ADDR, 32'h0);
        chk(rd, 32'h0100);
        apb(1'b0, `TCCD_DADDR_ADDR, 32'h0);
        chk(rd, 32'h7);
        chk(compare_irq, 1'b1);
        apb(1'b1, `TCCD_CTRL_ADDR, 32'h0);
        apb(1'b1, `TCCD_STAT_ADDR, 32'h3);
        lat <= 4'h3;
        load_cnt <= 16'h2;
        load_addr <= 16'h8;
        load <= 1'b1;
        apb(1'b1, `TCCD_CTRL_ADDR, 32'h08);
        load <= 1'b0;
        apb(1'b1, `TCCD_MASK_ADDR, 32'h40);
        for (int i = 1; i < 4; i++) begin
            apb(1'b1, `TCCD_COUNT_ADDR, 32'h1111 * i);
            capture_in <= 1'b1;
            repeat (8) @(posedge pclk);
            capture_in <= 1'b0;
            want = (i < 3) ? 16'(2 - i) : 16'h0;
            wait_on(1);
            repeat (4) @(posedge pclk);
        end
        wait_on(0);
        chk(capture_irq, 1'b1);
        chk(model.mem[8], 32'h1111);
        chk(model.mem[9], 32'h2222);
        apb(1'b0, `TCCD_CAPT_ADDR, 32'h0);
        chk(rd, 32'h3333);
        apb(1'b0, `TCCD_MASK_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(cap_out_valid, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(capture_irq, 1'b0);
        presetn <= 1'b1;
        apb(1'b0, `TCCD_CAPT_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `TCCD_CMP_ADDR, 32'h0);
        chk(rd, 32'hFFFF);
        final_report();
    end
endmodule : tb

bind tccd_timer tccd_timer_props props_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .compare_out, .compare_irq, .cap_dma_req,
    .cap_dma_ack, .cmp_dma_req, .cmp_dma_ack, .cap_block_done_event,
    .cmp_block_done_event);
